// ===== design/tmc_defs.svh
// Offsets, field positions, reset values and prescale counts for the timer shell
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// Register byte addresses
`define TMC_OFS_CTRL0 8'h00
`define TMC_OFS_CTRL1 8'h04
`define TMC_OFS_CNT_L 8'h08
`define TMC_OFS_CNT_H 8'h0c
`define TMC_OFS_CMPA_L 8'h10
`define TMC_OFS_CMPA_H 8'h14
`define TMC_OFS_CMPP_L 8'h18
`define TMC_OFS_CMPP_H 8'h1c
`define TMC_OFS_ROUTE 8'h20
`define TMC_OFS_STATUS 8'h24

// Control 0 fields
`define TMC_C0_PAUSE 7
`define TMC_C0_CKSEL_HI 6
`define TMC_C0_CKSEL_LO 4
`define TMC_C0_ON 3
`define TMC_C0_MASK 8'hf8

// Control 1 fields
`define TMC_C1_MODE_HI 7
`define TMC_C1_MODE_LO 6
`define TMC_C1_IO_HI 5
`define TMC_C1_IO_LO 4
`define TMC_C1_OC 3
`define TMC_C1_POL 2
`define TMC_C1_DPX 1
`define TMC_C1_CCLR 0

// Pin route fields, both variants share the implemented mask
`define TMC_RT_CLKOUT 7
`define TMC_RT_BIT2 2
`define TMC_RT_BIT1 1
`define TMC_RT_BIT0 0
`define TMC_RT_MASK 8'h87

// Reset values
`define TMC_RST_BYTE 8'h00

// Mode codes
`define TMC_MODE_CMP 2'b00
`define TMC_MODE_CAP 2'b01
`define TMC_MODE_PWM 2'b10
`define TMC_MODE_TMR 2'b11

// Output function codes
`define TMC_IO_LOW 2'b01
`define TMC_IO_HIGH 2'b10
`define TMC_IO_TGL 2'b11
`define TMC_IO_PWM 2'b10

// Clock select codes
`define TMC_CK_SYS4 3'b000
`define TMC_CK_SYS 3'b001
`define TMC_CK_H16 3'b010
`define TMC_CK_H64 3'b011
`define TMC_CK_TBC 3'b100
`define TMC_CK_H8 3'b101
`define TMC_CK_RISE 3'b110
`define TMC_CK_FALL 3'b111

// Prescale divide counts
`define TMC_DIV4 7'd4
`define TMC_DIV8 7'd8
`define TMC_DIV16 7'd16
`define TMC_DIV64 7'd64

`endif

// ===== design/tmc_pkg.sv
// Types shared by the timer shell modules
package tmc_pkg;
   typedef logic [7:0] tmc_byte_type;
   typedef logic [2:0] tmc_cksel_type;
   typedef logic [1:0] tmc_mode_type;
endpackage

// ===== design/tmc_tick.sv
// Counter clock selection, prescalers and external input edge detection
`timescale 1ns/1ns
`include "tmc_defs.svh"
module tmc_tick
   import tmc_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire tmc_cksel_type clock_source_select, // Source code
   input wire logic timer_clock_input, // External timer pin
   input wire logic time_base_clock, // Time-base clock, foreign domain
   output logic tick_r // One-cycle count enable
);
   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   logic [6:0] pre_r; // Free-running prescaler
   logic [6:0] pre_nxt;
   logic tck_s1_r; // First synchroniser stage
   logic tck_s2_r; // Second synchroniser stage
   logic tck_d_r; // Previous synchronised level
   logic tbc_s1_r;
   logic tbc_s2_r;
   logic tbc_d_r;
   logic tick_nxt;

   // Division tick when prescaler wraps its period
   function automatic logic div_hit(input logic [6:0] cnt, input logic [6:0] div);
      div_hit = ((cnt & (div - 7'd1)) == (div - 7'd1));
   endfunction

   //------------------------------------------------------------
   // Next values
   //------------------------------------------------------------
   // High clock taken as the system clock here; one prescaler serves all ratios
   always_comb
   begin
      pre_nxt = pre_r + 7'd1;
      tick_nxt = 1'b0;
      case (clock_source_select)
         `TMC_CK_SYS4: tick_nxt = div_hit(pre_r, `TMC_DIV4);
         `TMC_CK_SYS: tick_nxt = 1'b1;
         `TMC_CK_H16: tick_nxt = div_hit(pre_r, `TMC_DIV16);
         `TMC_CK_H64: tick_nxt = div_hit(pre_r, `TMC_DIV64);
         `TMC_CK_TBC: tick_nxt = tbc_s2_r & ~tbc_d_r;
         `TMC_CK_H8: tick_nxt = div_hit(pre_r, `TMC_DIV8);
         `TMC_CK_RISE: tick_nxt = tck_s2_r & ~tck_d_r;
         `TMC_CK_FALL: tick_nxt = ~tck_s2_r & tck_d_r;
         default: tick_nxt = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   // Edge detectors read only the second stage, never the first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_r <= 7'h00;
         tck_s1_r <= 1'b0;
         tck_s2_r <= 1'b0;
         tck_d_r <= 1'b0;
         tbc_s1_r <= 1'b0;
         tbc_s2_r <= 1'b0;
         tbc_d_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else
      begin
         pre_r <= pre_nxt;
         tck_s1_r <= timer_clock_input;
         tck_s2_r <= tck_s1_r;
         tck_d_r <= tck_s2_r;
         tbc_s1_r <= time_base_clock;
         tbc_s2_r <= tbc_s1_r;
         tbc_d_r <= tbc_s2_r;
         tick_r <= tick_nxt;
      end
   end
endmodule

// ===== design/tmc_timer.sv
// Timer module shell: APB registers, counter, comparators, pin routing
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "tmc_defs.svh"
module tmc_timer
   import tmc_pkg::*;
#(
   parameter int CW = 16, // Counter and compare A width
   parameter int PW = 10, // Compare P width
   parameter bit LARGE = 1'b1, // Pin route layout: 1 large, 0 small
   parameter int OWN_PIN = 2 // Which output pin this timer owns
)
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic timer_clock_input, // External clock pin
   input wire logic time_base_clock, // Time-base clock
   input wire logic timer_output_pin_i, // Output pin level as input
   output logic timer_output_pin_o, // Output pin drive value
   output logic timer_output_pin_oe, // Output pin enable
   output logic timer_clock_claim, // Input pin taken by timer
   output logic irq_a, // Comparator A match pulse
   output logic irq_p, // Comparator P match pulse
   output logic clock_out_pin_enable, // Clock-out pin route
   output logic output0_pin_enable, // Output 0 route
   output logic output1_alt_a_enable, // Output 1 route, first site
   output logic output1_alt_b_enable, // Output 1 route, second site
   output logic output2_pin_enable // Output 2 route
);
   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   logic [7:0] c0_r, c0_nxt; // Control 0
   logic [7:0] c1_r, c1_nxt; // Control 1
   logic [7:0] route_r, route_nxt; // Pin route
   logic [7:0] hold_r, hold_nxt; // Shared low-byte buffer
   logic [CW-1:0] cmpa_r, cmpa_nxt; // Compare A or capture
   logic [PW-1:0] cmpp_r, cmpp_nxt; // Compare P
   logic [CW-1:0] cnt_r, cnt_nxt; // Counter
   logic out_r, out_nxt; // Internal output level
   logic on_d_r; // Previous on bit
   logic cap_s1_r, cap_s2_r, cap_d_r; // Pin input sync and edge
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;
   logic claim_r, irq_a_r, irq_a_nxt, irq_p_r, irq_p_nxt;
   logic [4:0] rt_out_r, rt_out_nxt; // Route outputs
   logic tick; // Count enable from clock selector
   logic done; // Transfer completes this edge
   logic wr, rd; // Completing write or read
   logic mapped; // Address decodes
   logic own_en; // Route bit for this timer's pin
   logic match_a, match_p, start;
   logic pwm_act;
   tmc_mode_type mode;
   logic [1:0] io;
   tmc_byte_type wb;

   // Byte of a right-aligned value, high when hi is set
   function automatic tmc_byte_type pick(input logic [15:0] v, input logic hi);
      pick = hi ? v[15:8] : v[7:0];
   endfunction

   //------------------------------------------------------------
   // Clock source
   //------------------------------------------------------------
   tmc_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .clock_source_select(c0_r[`TMC_C0_CKSEL_HI:`TMC_C0_CKSEL_LO]),
      .timer_clock_input(timer_clock_input),
      .time_base_clock(time_base_clock),
      .tick_r(tick)
   );

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   // Answer comes on the second access cycle; effects land only then
   assign done = psel & penable & pready_r;
   assign wr = done & pwrite;
   assign rd = done & ~pwrite;
   assign wb = pwdata[7:0];
   assign mode = c1_r[`TMC_C1_MODE_HI:`TMC_C1_MODE_LO];
   assign io = c1_r[`TMC_C1_IO_HI:`TMC_C1_IO_LO];
   assign start = c0_r[`TMC_C0_ON] & ~on_d_r;
   always_comb
   begin
      case (paddr)
         `TMC_OFS_CTRL0, `TMC_OFS_CTRL1, `TMC_OFS_CNT_L, `TMC_OFS_CNT_H,
         `TMC_OFS_CMPA_L, `TMC_OFS_CMPA_H, `TMC_OFS_CMPP_L, `TMC_OFS_CMPP_H,
         `TMC_OFS_ROUTE, `TMC_OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0; // Unmapped: error, reads zero
      endcase
   end

   // This timer's pin enable; small layout gives output 1 two sites
   always_comb
   begin
      if (OWN_PIN == 1 && !LARGE)
         own_en = route_r[`TMC_RT_BIT1] | route_r[`TMC_RT_BIT2];
      else if (OWN_PIN == 2)
         own_en = route_r[`TMC_RT_BIT2];
      else if (OWN_PIN == 1)
         own_en = route_r[`TMC_RT_BIT1];
      else
         own_en = route_r[`TMC_RT_BIT0];
   end

   //------------------------------------------------------------
   // Comparators
   //------------------------------------------------------------
   // P compares the top bits of the counter
   assign match_a = tick & (cnt_r == cmpa_r);
   assign match_p = tick & (cnt_r[CW-1 -: PW] == cmpp_r);
   assign pwm_act = c1_r[`TMC_C1_DPX] ? (cnt_r[CW-1 -: PW] < cmpp_r) : (cnt_r < cmpa_r);

   //------------------------------------------------------------
   // Bus next values
   //------------------------------------------------------------
   always_comb
   begin
      pready_nxt = psel & penable & ~pready_r;
      pslverr_nxt = psel & penable & ~pready_r & ~mapped;
      prdata_nxt = prdata_r;
      if (psel & penable & ~pready_r & ~pwrite)
      begin
         prdata_nxt = 32'h0000_0000;
         case (paddr)
            `TMC_OFS_CTRL0: prdata_nxt[7:0] = c0_r;
            `TMC_OFS_CTRL1: prdata_nxt[7:0] = c1_r;
            `TMC_OFS_CNT_L, `TMC_OFS_CMPA_L, `TMC_OFS_CMPP_L: prdata_nxt[7:0] = hold_r;
            `TMC_OFS_CNT_H: prdata_nxt[7:0] = pick(16'(cnt_r), 1'b1);
            `TMC_OFS_CMPA_H: prdata_nxt[7:0] = pick(16'(cmpa_r), 1'b1);
            `TMC_OFS_CMPP_H: prdata_nxt[7:0] = pick(16'(cmpp_r), 1'b1);
            `TMC_OFS_ROUTE: prdata_nxt[7:0] = route_r & `TMC_RT_MASK;
            `TMC_OFS_STATUS: prdata_nxt[1:0] = {pin_o_r, c0_r[`TMC_C0_ON] & ~c0_r[`TMC_C0_PAUSE]};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   //------------------------------------------------------------
   // Register file next values
   //------------------------------------------------------------
   // Only the holding buffer and high bytes move on low/high accesses
   always_comb
   begin
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      route_nxt = route_r;
      hold_nxt = hold_r;
      cmpa_nxt = cmpa_r;
      cmpp_nxt = cmpp_r;
      if (wr)
      begin
         case (paddr)
            `TMC_OFS_CTRL0: c0_nxt = wb & `TMC_C0_MASK;
            `TMC_OFS_CTRL1: c1_nxt = wb;
            `TMC_OFS_CMPA_L, `TMC_OFS_CMPP_L: hold_nxt = wb;
            `TMC_OFS_CMPA_H: cmpa_nxt = CW'({wb, hold_r});
            `TMC_OFS_CMPP_H: cmpp_nxt = PW'({wb, hold_r});
            `TMC_OFS_ROUTE: route_nxt = wb & `TMC_RT_MASK;
            default: hold_nxt = hold_r;
         endcase
      end
      else if (rd)
      begin
         case (paddr)
            `TMC_OFS_CNT_H: hold_nxt = pick(16'(cnt_r), 1'b0);
            `TMC_OFS_CMPA_H: hold_nxt = pick(16'(cmpa_r), 1'b0);
            `TMC_OFS_CMPP_H: hold_nxt = pick(16'(cmpp_r), 1'b0);
            default: hold_nxt = hold_r;
         endcase
      end
      // Capture mode stores the counter in compare A on a pin rising edge
      if (mode == `TMC_MODE_CAP && own_en && cap_s2_r && !cap_d_r)
         cmpa_nxt = cnt_r;
   end

   //------------------------------------------------------------
   // Counter and output next values
   //------------------------------------------------------------
   always_comb
   begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      irq_a_nxt = 1'b0;
      irq_p_nxt = 1'b0;
      if (start)
      begin
         cnt_nxt = '0; // Off to on restarts from zero
         out_nxt = c1_r[`TMC_C1_OC];
      end
      else if (c0_r[`TMC_C0_ON] && !c0_r[`TMC_C0_PAUSE] && tick)
      begin
         irq_a_nxt = match_a;
         irq_p_nxt = match_p;
         if (mode == `TMC_MODE_PWM)
         begin
            // Period comparator closes the cycle
            if (c1_r[`TMC_C1_DPX] ? match_a : match_p)
               cnt_nxt = '0;
            else
               cnt_nxt = cnt_r + CW'(1);
         end
         else if (c1_r[`TMC_C1_CCLR] ? match_a : match_p)
            cnt_nxt = '0;
         else
            cnt_nxt = cnt_r + CW'(1);
         if (mode == `TMC_MODE_CMP && match_a)
         begin
            case (io)
               `TMC_IO_LOW: out_nxt = 1'b0;
               `TMC_IO_HIGH: out_nxt = 1'b1;
               `TMC_IO_TGL: out_nxt = ~out_r;
               default: out_nxt = out_r;
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // Pin drive next values
   //------------------------------------------------------------
   // Polarity inverts the pin, not the internal level
   always_comb
   begin
      pin_o_nxt = out_r ^ c1_r[`TMC_C1_POL];
      pin_oe_nxt = 1'b0;
      case (mode)
         `TMC_MODE_CMP: pin_oe_nxt = own_en;
         `TMC_MODE_PWM:
         begin
            pin_oe_nxt = own_en;
            if (io == `TMC_IO_PWM)
               pin_o_nxt = (pwm_act ~^ c1_r[`TMC_C1_OC]) ^ c1_r[`TMC_C1_POL];
            else
               pin_o_nxt = (io[0] ~^ c1_r[`TMC_C1_OC]) ^ c1_r[`TMC_C1_POL];
         end
         default: pin_oe_nxt = 1'b0; // Capture and timer leave pin undriven
      endcase
      // Small layout: output 1 sites follow bits 1 and 2, software keeps one set; large holds the second site off
      if (LARGE)
         rt_out_nxt = {route_r[`TMC_RT_CLKOUT], route_r[`TMC_RT_BIT0], route_r[`TMC_RT_BIT1],
                       1'b0, route_r[`TMC_RT_BIT2]};
      else
         rt_out_nxt = {route_r[`TMC_RT_CLKOUT], route_r[`TMC_RT_BIT0], route_r[`TMC_RT_BIT1],
                       route_r[`TMC_RT_BIT2], 1'b0};
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c0_r <= `TMC_RST_BYTE;
         c1_r <= `TMC_RST_BYTE;
         route_r <= `TMC_RST_BYTE;
         hold_r <= `TMC_RST_BYTE;
         cmpa_r <= '0;
         cmpp_r <= '0;
         cnt_r <= '0;
         out_r <= 1'b0;
         on_d_r <= 1'b0;
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_d_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         pin_o_r <= 1'b0;
         pin_oe_r <= 1'b0;
         claim_r <= 1'b0;
         irq_a_r <= 1'b0;
         irq_p_r <= 1'b0;
         rt_out_r <= 5'h00;
      end
      else
      begin
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         route_r <= route_nxt;
         hold_r <= hold_nxt;
         cmpa_r <= cmpa_nxt;
         cmpp_r <= cmpp_nxt;
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
         on_d_r <= c0_r[`TMC_C0_ON];
         cap_s1_r <= timer_output_pin_i;
         cap_s2_r <= cap_s1_r;
         cap_d_r <= cap_s2_r;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         pin_o_r <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         claim_r <= (c0_r[`TMC_C0_CKSEL_HI:`TMC_C0_CKSEL_HI-1] == 2'b11);
         irq_a_r <= irq_a_nxt;
         irq_p_r <= irq_p_nxt;
         rt_out_r <= rt_out_nxt;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timer_output_pin_o = pin_o_r;
   assign timer_output_pin_oe = pin_oe_r;
   assign timer_clock_claim = claim_r;
   assign irq_a = irq_a_r;
   assign irq_p = irq_p_r;
   assign clock_out_pin_enable = rt_out_r[4];
   assign output0_pin_enable = rt_out_r[3];
   assign output1_alt_a_enable = rt_out_r[2];
   assign output1_alt_b_enable = rt_out_r[1];
   assign output2_pin_enable = rt_out_r[0];
endmodule

// ===== dv/tmc_timer_monitor.sv
// Checker for the timer shell register bus and pin routing
`timescale 1ns/1ns
`include "tmc_defs.svh"
module tmc_timer_monitor
#(
   parameter bit LARGE = 1'b1 // Route layout
)
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Access phase
   input wire logic pwrite, // Direction
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic timer_clock_claim, // Input pin claim
   input wire logic irq_a, // Match A
   input wire logic irq_p, // Match P
   input wire logic clock_out_pin_enable, // Route bit 7
   input wire logic output0_pin_enable, // Route bit 0
   input wire logic output1_alt_b_enable // Second site
);
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   logic acc; // Completed transfer
   logic mapped; // Address decodes
   assign acc = psel && penable && pready;
   assign mapped = (paddr <= `TMC_OFS_STATUS) && (paddr[1:0] == 2'b00);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   ready_one_wait_a:
      assert property (psel && $rose(penable) |=> pready) else $error("ready late");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready held");
   upper_zero_a:
      assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   route_hole_a:
      assert property (acc && !pwrite && paddr == `TMC_OFS_ROUTE |-> prdata[6:3] == 4'h0)
         else $error("route hole bits set");
   slverr_map_a:
      assert property (acc |-> pslverr == !mapped) else $error("error flag wrong");
   route_follow_a:
      assert property (acc && pwrite && paddr == `TMC_OFS_ROUTE |-> ##2
         (clock_out_pin_enable == $past(pwdata[7], 2) && output0_pin_enable == $past(pwdata[0], 2)))
         else $error("route outputs lag");
   alt_b_off_a:
      assert property (LARGE |-> !output1_alt_b_enable) else $error("second site on");
   claim_follow_a:
      assert property (acc && pwrite && paddr == `TMC_OFS_CTRL0 |-> ##2
         (timer_clock_claim == ($past(pwdata[6:5], 2) == 2'b11))) else $error("claim wrong");
   // Main scenarios reached
   cover property (irq_a);
   cover property (irq_p);
   cover property ($rose(timer_clock_claim));
endmodule

bind tmc_timer tmc_timer_monitor #(.LARGE(LARGE)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_clock_claim(timer_clock_claim), .irq_a(irq_a), .irq_p(irq_p),
   .clock_out_pin_enable(clock_out_pin_enable), .output0_pin_enable(output0_pin_enable),
   .output1_alt_b_enable(output1_alt_b_enable));

// ===== dv/tmc_pin_model.sv
// External clock source, time-base clock and shared pin model
`timescale 1ns/1ns
module tmc_pin_model
(
   input wire logic pclk, // System clock
   input wire logic timer_output_pin_o, // Timer drive value
   input wire logic timer_output_pin_oe, // Timer drives pin
   output logic timer_clock_input, // External count pin
   output logic time_base_clock, // Time-base clock
   output logic timer_output_pin_i // Pin level seen back
);
   logic idle_r; // Pattern while pin released
   int tb_cnt; // Time-base divider
   initial
   begin
      timer_clock_input = 1'b0;
      time_base_clock = 1'b0;
      idle_r = 1'b0;
      tb_cnt = 0;
   end
   // Time-base clock runs free, one rise every 14 cycles
   always @(posedge pclk)
   begin
      idle_r <= ~idle_r;
      tb_cnt <= (tb_cnt == 6) ? 0 : tb_cnt + 1;
      if (tb_cnt == 6)
         time_base_clock <= ~time_base_clock;
   end
   // Released pin toggles so a stale level never looks valid
   assign timer_output_pin_i = timer_output_pin_oe ? timer_output_pin_o : idle_r;
   // Slow external pulses, one rising and one falling edge each
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge pclk) timer_clock_input <= 1'b1;
         repeat (4) @(posedge pclk);
         timer_clock_input <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the timer shell
`timescale 1ns/1ns
`include "tmc_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite; // Clock, reset, bus
   logic [7:0] paddr; // Address
   logic [31:0] pwdata, prdata; // Data
   logic pready, pslverr, tci, tbc, pin_i, pin_o, pin_oe, claim, irq_a, irq_p; // Pins
   logic ck_out, out0, alt_a, alt_b, out2; // Route outputs
   logic [7:0] q, r; // Read byte, route value
   logic [15:0] v, w; // Wide values
   logic last_err; // Error of last transfer
   int mismatches, comparisons, cyc, a, p, t; // Counters
   //------------------------------------------------------------
   // Clock, design and far side
   //------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   tmc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_clock_input(tci), .time_base_clock(tbc), .timer_output_pin_i(pin_i),
      .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe), .timer_clock_claim(claim),
      .irq_a(irq_a), .irq_p(irq_p), .clock_out_pin_enable(ck_out), .output0_pin_enable(out0),
      .output1_alt_a_enable(alt_a), .output1_alt_b_enable(alt_b), .output2_pin_enable(out2));
   tmc_pin_model model (.pclk(pclk), .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe),
      .timer_clock_input(tci), .time_base_clock(tbc), .timer_output_pin_i(pin_i));
   //------------------------------------------------------------
   // Expectations and bus tasks
   //------------------------------------------------------------
   // Ticks per count for select codes 0..5; time base rises every 14
   function automatic int div_of(input int c);
      int tab[6] = '{4, 1, 16, 64, 14, 8};
      return tab[c];
   endfunction
   // Pin level after a match for a given io code and initial bit
   function automatic logic lvl_of(input int io, input logic oc);
      return (io == 0) ? oc : (io == 2);
   endfunction
   // One transfer; taken and released at the ready edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] d, output logic [7:0] rd);
      @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, 24'h0, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      last_err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
      apb(1, lo, d[7:0], q);
      apb(1, lo + 8'h04, d[15:8], q);
   endtask
   task automatic rd16(input logic [7:0] hi, output logic [15:0] d);
      apb(0, hi, 8'h00, d[15:8]);
      apb(0, hi - 8'h04, 8'h00, d[7:0]);
   endtask
   // Count match pulses and pin changes over n cycles
   task automatic cnt(input int n);
      logic prev;
      prev = pin_o;
      {a, p, t} = '0;
      repeat (n) @(negedge pclk)
      begin
         a += (irq_a === 1'b1);
         p += (irq_p === 1'b1);
         t += (pin_o !== prev);
         prev = pin_o;
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, cyc, mismatches, comparisons} = '0;
      q = $urandom(84);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and route layout
      apb(0, `TMC_OFS_ROUTE, 8'h00, q);
      `CHK("route_rst", 8'h00, q)
      for (int i = 0; i < 4; i++)
      begin
         r = (i == 0) ? 8'hff : 8'($urandom);
         apb(1, `TMC_OFS_ROUTE, r, q);
         apb(0, `TMC_OFS_ROUTE, 8'h00, q);
         `CHK("route_rd", r & 8'h87, q)
         `CHK("route_pins", {r[7], r[0], r[1], r[2]}, {ck_out, out0, alt_a, out2})
      end
      // Unmapped place refuses and reads zero
      apb(0, 8'h28, 8'h00, q);
      `CHK("unmapped_rd", 9'h100, {last_err, q})
      // Buffered low byte: lone low write must not reach the register
      for (int i = 0; i < 3; i++)
      begin
         v = 16'($urandom);
         wr16(`TMC_OFS_CMPA_L, v);
         rd16(`TMC_OFS_CMPA_H, w);
         `CHK("cmpa", v, w)
         apb(1, `TMC_OFS_CMPA_L, ~v[7:0], q);
         rd16(`TMC_OFS_CMPA_H, w);
         `CHK("cmpa_lone_low", v, w)
         wr16(`TMC_OFS_CMPP_L, v);
         rd16(`TMC_OFS_CMPP_H, w);
         `CHK("cmpp", v & 16'h03ff, w)
      end
      // Every internal clock code; match at 2 clears and toggles
      apb(1, `TMC_OFS_ROUTE, 8'h04, q);
      apb(1, `TMC_OFS_CTRL1, 8'h31, q);
      wr16(`TMC_OFS_CMPA_L, 16'h0002);
      for (int c = 0; c < 6; c++)
      begin
         apb(1, `TMC_OFS_CTRL0, 8'h00, q);
         apb(1, `TMC_OFS_CTRL0, {1'b0, 3'(c), 4'h8}, q);
         repeat (6 * div_of(c)) @(posedge pclk);
         cnt(12 * div_of(c));
         `CHK("irq_a_count", 4, a)
         `CHK("pin_toggles", 4, t)
         `CHK("pin_oe_claim", 2'b10, {pin_oe, claim})
      end
      // Set-low, set-high and no-change output functions
      for (int io = 0; io < 3; io++)
      begin
         apb(1, `TMC_OFS_CTRL0, 8'h00, q);
         apb(1, `TMC_OFS_CTRL1, {2'b00, 2'(io), (io != 2), 3'b001}, q);
         apb(1, `TMC_OFS_CTRL0, 8'h18, q);
         repeat (20) @(negedge pclk);
         `CHK("pin_level", lvl_of(io, io != 2), pin_o)
      end
      // Comparator P on counter bits 15:6 clears at 64
      apb(1, `TMC_OFS_CTRL0, 8'h00, q);
      apb(1, `TMC_OFS_CTRL1, 8'h30, q);
      wr16(`TMC_OFS_CMPA_L, 16'h0020);
      wr16(`TMC_OFS_CMPP_L, 16'h0001);
      apb(1, `TMC_OFS_CTRL0, 8'h18, q);
      repeat (70) @(posedge pclk);
      cnt(195);
      `CHK("irq_p_count", 3, p)
      // External pin, rising then falling edges
      for (int k = 0; k < 2; k++)
      begin
         apb(1, `TMC_OFS_CTRL0, 8'h00, q);
         apb(1, `TMC_OFS_CTRL0, k ? 8'h78 : 8'h68, q);
         repeat (4) @(negedge pclk);
         `CHK("claim", 1'b1, claim)
         model.pulse(5 + k);
         repeat (8) @(posedge pclk);
         rd16(`TMC_OFS_CNT_H, w);
         `CHK("ext_count", 16'(5 + k), w)
      end
      // PWM output
      apb(1, `TMC_OFS_CTRL1, 8'ha8, q);
      apb(1, `TMC_OFS_CTRL0, 8'h18, q);
      cnt(130);
      `CHK("pwm_edges", 4, t)
      end_sim();
   end
endmodule
